// ---- design/rsx_pkg.sv ----
package rsx_pkg;
  // Opcodes
  localparam logic [7:0] OP_PUSH_INC = 8'h83;
  localparam logic [7:0] OP_CLR_CARRY = 8'hcf;
  localparam logic [7:0] OP_RETURN = 8'haf;
  localparam logic [7:0] OP_ROL_DIR = 8'h90;
  localparam logic [7:0] OP_ROL_IND = 8'h91;
  localparam logic [7:0] OP_RLC_DIR = 8'h10;
  localparam logic [7:0] OP_RLC_IND = 8'h11;
  localparam logic [7:0] OP_ROR_DIR = 8'he0;
  localparam logic [7:0] OP_ROR_IND = 8'he1;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_PUSH = 2'h3;
  localparam logic [1:0] LEN_CLR = 2'h1;
  localparam logic [1:0] LEN_RET = 2'h1;
  localparam logic [1:0] LEN_ROT = 2'h2;
  // Cycle counts
  localparam logic [3:0] CYC_PUSH = 4'h8;
  localparam logic [3:0] CYC_CLR = 4'h4;
  localparam logic [3:0] CYC_RET_INT = 4'h8;
  localparam logic [3:0] CYC_RET_EXT = 4'ha;
  localparam logic [3:0] CYC_ROT = 4'h4;
  // Stack pointer step on return
  localparam logic [15:0] RET_SP_STEP = 16'h0002;
  // Flag bit positions in the flags byte
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [15:0] PC_RST = 16'h0000;
endpackage

// ---- design/rsx_exec.sv ----
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// Notes on behaviour
// - Incrementing push adds one to user pointer, then writes source there.
// - Incrementing push is three bytes, eight cycles, flags untouched.
// - Clear-carry, opcode CF, one byte, four cycles, clears only carry.
// - Return, opcode AF, loads PC from stack then adds two to SP.
// - Byte at SP becomes PC high byte, next byte becomes low byte.
// - Fetch continues at new PC; return takes eight or ten cycles.
// - Rotate left moves bit 7 into bit 0 and carry; opcodes 90/91.
// - Plain rotate left sets overflow on arithmetic overflow.
// - Rotate left through carry: old carry to bit 0; opcodes 10/11.
// - Rotate right moves bit 0 into bit 7 and carry; opcodes E0/E1.
// - Carry equals bit shifted out: bit 7 left, bit 0 right.
// - Rotates set zero and sign from result; D and H unchanged.
// - Through-carry left and plain right rotate set overflow on sign change.
// - Every rotate is two bytes and four cycles in both forms.
module rsx_exec
  import rsx_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  // Instruction issue
  input wire logic start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] dst_in,
  input wire logic [7:0] src_in,
  input wire logic ext_stack_in,
  // Register file and stack memory port
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  // Architectural state
  output logic [7:0] flags_out,
  output logic [15:0] pc_out,
  output logic [15:0] sp_out,
  // Completion
  output logic busy_out,
  output logic done_out,
  output logic fetch_out,
  output logic [1:0] len_out,
  output logic illegal_out
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RD1 = 7'b0000010,
    ST_RD2 = 7'b0000100,
    ST_RD3 = 7'b0001000,
    ST_EXEC = 7'b0010000,
    ST_WAIT = 7'b0100000,
    ST_DONE = 7'b1000000
  } rsx_state_t;

  function automatic logic is_rotate(input logic [7:0] op);
    is_rotate = (op[7:1] == OP_ROL_DIR[7:1]) ||
                (op[7:1] == OP_RLC_DIR[7:1]) ||
                (op[7:1] == OP_ROR_DIR[7:1]);
  endfunction

  function automatic logic is_known(input logic [7:0] op);
    is_known = is_rotate(op) || op == OP_PUSH_INC ||
               op == OP_CLR_CARRY || op == OP_RETURN;
  endfunction

  rsx_state_t state_ff;
  logic [7:0] op_ff;
  logic [7:0] dst_ff;
  logic [7:0] src_ff;
  logic [7:0] ptr_ff;
  logic [7:0] opnd_ff;
  logic [7:0] hi_ff;
  logic [3:0] cyc_ff;
  logic [3:0] target_ff;
  logic [7:0] rot_res;
  logic rot_c;
  logic rot_v;

  ////////////////////////////////////////////////////////////////////////////
  // Rotate datapath on the fetched operand
  always_comb
  begin
    rot_res = opnd_ff;
    rot_c = flags_out[FLG_C];
    rot_v = 1'b0;
    case (op_ff[7:1])
      OP_ROL_DIR[7:1]:
      begin
        rot_res = {opnd_ff[6:0], opnd_ff[7]};
        rot_c = opnd_ff[7];
        // Sign change is the overflow condition of a left shift
        rot_v = opnd_ff[7] ^ opnd_ff[6];
      end
      OP_RLC_DIR[7:1]:
      begin
        rot_res = {opnd_ff[6:0], flags_out[FLG_C]};
        rot_c = opnd_ff[7];
        rot_v = opnd_ff[7] ^ opnd_ff[6];
      end
      OP_ROR_DIR[7:1]:
      begin
        rot_res = {opnd_ff[0], opnd_ff[7:1]};
        rot_c = opnd_ff[0];
        rot_v = opnd_ff[7] ^ opnd_ff[0];
      end
      default:
      begin
        rot_res = opnd_ff;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: memory reads take one cycle, padding fills to the cycle count
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      op_ff <= 8'h00;
      dst_ff <= 8'h00;
      src_ff <= 8'h00;
      target_ff <= 4'h0;
      cyc_ff <= 4'h0;
    end
    else if (clk_en_in)
    begin
      cyc_ff <= (state_ff == ST_IDLE) ? 4'h1 : cyc_ff + 4'h1;
      case (state_ff)
        ST_IDLE:
        begin
          if (start_in && is_known(opcode_in))
          begin
            op_ff <= opcode_in;
            dst_ff <= dst_in;
            src_ff <= src_in;
            if (opcode_in == OP_PUSH_INC)
              target_ff <= CYC_PUSH;
            else if (opcode_in == OP_CLR_CARRY)
              target_ff <= CYC_CLR;
            else if (opcode_in == OP_RETURN)
              target_ff <= ext_stack_in ? CYC_RET_EXT : CYC_RET_INT;
            else
              target_ff <= CYC_ROT;
            state_ff <= (opcode_in == OP_CLR_CARRY) ? ST_EXEC : ST_RD1;
          end
        end
        ST_RD1:
        begin
          // Direct rotates have no pointer hop
          if (is_rotate(op_ff) && !op_ff[0])
            state_ff <= ST_RD3;
          else
            state_ff <= ST_RD2;
        end
        ST_RD2:
        begin
          // Indirect rotates skip the spare slot to stay at four cycles
          if (is_rotate(op_ff))
            state_ff <= ST_EXEC;
          else
            state_ff <= ST_RD3;
        end
        ST_RD3:
          state_ff <= ST_EXEC;
        ST_EXEC:
          state_ff <= ST_WAIT;
        ST_WAIT:
          if (cyc_ff >= target_ff)
            state_ff <= ST_DONE;
        ST_DONE:
          state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_addr_out <= 16'h0000;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
    end
    else if (clk_en_in)
    begin
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      case (state_ff)
        ST_IDLE:
          if (start_in && is_known(opcode_in) && opcode_in != OP_CLR_CARRY)
          begin
            mem_rd_out <= 1'b1;
            if (opcode_in == OP_RETURN)
              mem_addr_out <= sp_out;
            else
              mem_addr_out <= {8'h00, dst_in};
          end
        ST_RD1:
        begin
          mem_rd_out <= 1'b1;
          if (op_ff == OP_RETURN)
            mem_addr_out <= sp_out + 16'h0001;
          else if (op_ff == OP_PUSH_INC)
            mem_addr_out <= {8'h00, src_ff};
          else if (op_ff[0])
            mem_addr_out <= {8'h00, mem_rdata_in};
          else
            mem_rd_out <= 1'b0;
        end
        ST_RD3:
          if (op_ff == OP_PUSH_INC)
          begin
            // Pointer bumped first, then data goes to the new slot
            mem_wr_out <= 1'b1;
            mem_addr_out <= {8'h00, dst_ff};
            mem_wdata_out <= ptr_ff + 8'h01;
          end
        ST_EXEC:
          if (op_ff == OP_PUSH_INC)
          begin
            mem_wr_out <= 1'b1;
            mem_addr_out <= {8'h00, ptr_ff + 8'h01};
            mem_wdata_out <= opnd_ff;
          end
          else if (is_rotate(op_ff))
          begin
            mem_wr_out <= 1'b1;
            // Result returns to the same location it was read from
            mem_addr_out <= op_ff[0] ? {8'h00, ptr_ff} : {8'h00, dst_ff};
            mem_wdata_out <= rot_res;
          end
        default:
        begin
          mem_rd_out <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand capture: reads answer in the same cycle as the strobe
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ptr_ff <= 8'h00;
      opnd_ff <= 8'h00;
      hi_ff <= 8'h00;
    end
    else if (clk_en_in)
    begin
      if (state_ff == ST_RD1)
      begin
        ptr_ff <= mem_rdata_in;
        hi_ff <= mem_rdata_in;
        if (is_rotate(op_ff) && !op_ff[0])
          opnd_ff <= mem_rdata_in;
      end
      else if (state_ff == ST_RD2)
        opnd_ff <= mem_rdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, PC and SP
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flags_out <= FLAGS_RST;
      pc_out <= PC_RST;
      sp_out <= SP_RST;
    end
    else if (clk_en_in && state_ff == ST_EXEC)
    begin
      if (op_ff == OP_CLR_CARRY)
        flags_out[FLG_C] <= 1'b0;
      else if (op_ff == OP_RETURN)
      begin
        pc_out <= {hi_ff, opnd_ff};
        sp_out <= sp_out + RET_SP_STEP;
      end
      else if (is_rotate(op_ff))
      begin
        flags_out[FLG_C] <= rot_c;
        flags_out[FLG_Z] <= (rot_res == 8'h00);
        flags_out[FLG_S] <= rot_res[7];
        flags_out[FLG_V] <= rot_v;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
      fetch_out <= 1'b0;
      len_out <= 2'h0;
      illegal_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_out <= (state_ff == ST_WAIT) && (cyc_ff >= target_ff);
      fetch_out <= (state_ff == ST_WAIT) && (cyc_ff >= target_ff)
                   && op_ff == OP_RETURN;
      illegal_out <= (state_ff == ST_IDLE) && start_in &&
                     !is_known(opcode_in);
      if (state_ff == ST_IDLE && start_in && is_known(opcode_in))
      begin
        busy_out <= 1'b1;
        if (opcode_in == OP_PUSH_INC)
          len_out <= LEN_PUSH;
        else if (opcode_in == OP_CLR_CARRY)
          len_out <= LEN_CLR;
        else if (opcode_in == OP_RETURN)
          len_out <= LEN_RET;
        else
          len_out <= LEN_ROT;
      end
      else if (state_ff == ST_WAIT && cyc_ff >= target_ff)
        busy_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  busy_len_a: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(busy_out) |=> busy_out [*3]) else $error("busy too short");
  clr_carry_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_ff == ST_EXEC && op_ff == OP_CLR_CARRY) |=>
    !flags_out[FLG_C]) else $error("carry not cleared");
  clr_keep_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_ff == ST_EXEC && op_ff == OP_CLR_CARRY) |=>
    flags_out[6:0] == $past(flags_out[6:0])) else $error("flags hit");
  ret_sp_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_ff == ST_EXEC && op_ff == OP_RETURN) |=>
    sp_out == $past(sp_out) + 16'h0002) else $error("sp step");
  push_flags_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (op_ff == OP_PUSH_INC && state_ff != ST_IDLE) |=>
    $stable(flags_out)) else $error("push changed flags");
  rot_dh_a: assert property (@(posedge clock_in) disable iff (rst_in)
    is_rotate(op_ff) |=> $stable(flags_out[FLG_D:FLG_H]))
    else $error("D or H changed");
  rot_zero_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_ff == ST_EXEC && is_rotate(op_ff)) |=>
    flags_out[FLG_Z] == (mem_wdata_out == 8'h00)) else $error("zero");
  rot_wb_a: assert property (@(posedge clock_in) disable iff (rst_in)
    (clk_en_in && state_ff == ST_EXEC && is_rotate(op_ff) && op_ff[0]) |=>
    mem_wr_out && mem_addr_out[7:0] == ptr_ff) else $error("wb addr");

endmodule // rsx_exec

// ---- test/rsx_mem_model.sv ----
`timescale 1ns/100ps
module rsx_mem_model
(
  // Clock
  input wire logic clock_in,
  // Access port
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  output logic [7:0] mem_rdata_out
);
  // Only the low address byte decodes: registers and stack share it
  logic [7:0] mem_ff [256];
  initial
  begin
    foreach (mem_ff[i])
      mem_ff[i] = 8'h00;
  end
  always @(posedge clock_in)
  begin
    if (mem_wr_in)
      mem_ff[mem_addr_in[7:0]] <= mem_wdata_in;
  end
  // The core takes read data at the edge that ends its strobe cycle;
  // junk without a strobe so a stray capture shows up
  assign mem_rdata_out = mem_rd_in ? mem_ff[mem_addr_in[7:0]] : 8'ha5;
endmodule // rsx_mem_model

// ---- test/tb_rsx_exec.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, a, b); end end
module tb_rsx_exec
  import rsx_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic clk_en = 1'b1;
  logic start_in = 1'b0;
  logic ext_stack_in = 1'b0;
  logic [7:0] opcode_in = 8'h00;
  logic [7:0] dst_in = 8'h00;
  logic [7:0] src_in = 8'h00;
  logic [15:0] mem_addr, pc, sp;
  logic mem_rd, mem_wr, busy, done, fetch, illegal;
  logic [7:0] mem_wdata, mem_rdata, flags;
  logic [1:0] len;
  int errors = 0;
  int total_checks = 0;
  int bcnt = 0;
  logic dn = 1'b0;
  logic ill = 1'b0;
  logic fet = 1'b0;
  // Rotate cases in run order; flags carry over from one to the next
  localparam logic [7:0] T_OP [6] = '{8'h90, 8'h10, 8'he0,
    8'h91, 8'h11, 8'he1};
  localparam logic [7:0] T_VAL [6] = '{8'haa, 8'haa, 8'h31,
    8'h00, 8'h17, 8'h01};
  localparam logic [7:0] T_RES [6] = '{8'h55, 8'h55, 8'h98,
    8'h00, 8'h2e, 8'h80};
  localparam logic [7:0] T_FLG [6] = '{8'h90, 8'h90, 8'hb0,
    8'h40, 8'h00, 8'hb0};

  rsx_exec i_rsx_exec (.clock_in(clock_in), .rst_in(rst_in),
    .clk_en_in(clk_en), .start_in(start_in), .opcode_in(opcode_in),
    .dst_in(dst_in), .src_in(src_in), .ext_stack_in(ext_stack_in),
    .mem_addr_out(mem_addr), .mem_rd_out(mem_rd), .mem_wr_out(mem_wr),
    .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
    .flags_out(flags), .pc_out(pc), .sp_out(sp), .busy_out(busy),
    .done_out(done), .fetch_out(fetch), .len_out(len),
    .illegal_out(illegal));
  rsx_mem_model i_rsx_mem_model (.clock_in(clock_in),
    .mem_addr_in(mem_addr), .mem_rd_in(mem_rd), .mem_wr_in(mem_wr),
    .mem_wdata_in(mem_wdata), .mem_rdata_out(mem_rdata));

  initial
  begin
    forever #12.5 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    if (busy === 1'b1) bcnt++;
    if (done === 1'b1) dn = 1'b1;
    if (illegal === 1'b1) ill = 1'b1;
    if (fetch === 1'b1) fet = 1'b1;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Issue one instruction and return the busy cycles it took
  task automatic run(input logic [7:0] op, d, s, output int cyc);
    int b0;
    @(posedge clock_in);
    opcode_in <= op;
    dst_in <= d;
    src_in <= s;
    start_in <= 1'b1;
    @(posedge clock_in);
    start_in <= 1'b0;
    #1;
    dn = 1'b0;
    ill = 1'b0;
    fet = 1'b0;
    b0 = bcnt;
    for (int i = 0; i < 40 && !dn && !ill; i++)
    begin
      @(posedge clock_in);
      #1;
    end
    repeat (2) @(posedge clock_in);
    #1;
    cyc = bcnt - b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    int cyc;
    logic [7:0] a;
    logic [7:0] e;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    `CHK(flags, FLAGS_RST)
    `CHK(pc, PC_RST)
    for (int k = 0; k < 6; k++)
    begin
      a = T_OP[k][0] ? 8'h33 + k[7:0] : 8'h20 + k[7:0];
      i_rsx_mem_model.mem_ff[8'h20 + k] = a;
      i_rsx_mem_model.mem_ff[a] = T_VAL[k];
      run(T_OP[k], 8'h20 + k[7:0], 8'h00, cyc);
      `CHK(i_rsx_mem_model.mem_ff[a], T_RES[k])
      // A direct rotate has no pointer: its register holds the result
      e = T_OP[k][0] ? a : T_RES[k];
      `CHK(i_rsx_mem_model.mem_ff[8'h20 + k], e)
      `CHK(flags, T_FLG[k])
      `CHK(cyc, 4)
      `CHK(len, LEN_ROT)
      `CHK(dn, 1'b1)
    end
    run(8'hcf, 8'h00, 8'h00, cyc);
    `CHK(flags, 8'h30)
    `CHK(cyc, 4)
    `CHK(len, LEN_CLR)
    // Pointer 43 in reg 40, data 05 in reg 41
    i_rsx_mem_model.mem_ff[8'h40] = 8'h43;
    i_rsx_mem_model.mem_ff[8'h41] = 8'h05;
    i_rsx_mem_model.mem_ff[8'h44] = 8'h2a;
    run(8'h83, 8'h40, 8'h41, cyc);
    `CHK(i_rsx_mem_model.mem_ff[8'h40], 8'h44)
    `CHK(i_rsx_mem_model.mem_ff[8'h44], 8'h05)
    `CHK(i_rsx_mem_model.mem_ff[8'h43], 8'h00)
    `CHK(flags, 8'h30)
    `CHK(cyc, 8)
    `CHK(len, LEN_PUSH)
    // Two returns from stack at 0000 then 0002, internal then external timing
    i_rsx_mem_model.mem_ff[8'h00] = 8'h10;
    i_rsx_mem_model.mem_ff[8'h01] = 8'h1a;
    i_rsx_mem_model.mem_ff[8'h02] = 8'h12;
    i_rsx_mem_model.mem_ff[8'h03] = 8'h34;
    run(8'haf, 8'h00, 8'h00, cyc);
    `CHK(pc, 16'h101a)
    `CHK(sp, 16'h0002)
    `CHK(cyc, 8)
    `CHK(fet, 1'b1)
    ext_stack_in <= 1'b1;
    run(8'haf, 8'h00, 8'h00, cyc);
    `CHK(pc, 16'h1234)
    `CHK(sp, 16'h0004)
    `CHK(cyc, 10)
    `CHK(len, LEN_RET)
    `CHK(flags, 8'h30)
    // Unknown opcode is refused and changes nothing
    run(8'h4f, 8'h40, 8'h41, cyc);
    `CHK(ill, 1'b1)
    `CHK(flags, 8'h30)
    `CHK(i_rsx_mem_model.mem_ff[8'h40], 8'h44)
    // A frozen core ignores an issue and keeps its state
    clk_en <= 1'b0;
    run(8'h91, 8'h24, 8'h00, cyc);
    `CHK(dn, 1'b0)
    `CHK(cyc, 0)
    `CHK(i_rsx_mem_model.mem_ff[8'h37], 8'h2e)
    `CHK(flags, 8'h30)
    clk_en <= 1'b1;
    // Reset while the core is idle, then a return straight after it
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    `CHK(flags, FLAGS_RST)
    `CHK(sp, SP_RST)
    `CHK(busy, 1'b0)
    run(8'haf, 8'h00, 8'h00, cyc);
    `CHK(pc, 16'h101a)
    `CHK(cyc, 10)
    end_sim();
  end

  // Whole run is well under 1000 cycles
  initial
  begin
    #100000;
    errors++;
    end_sim();
  end
endmodule // tb_rsx_exec
